// [design/converter_startup_sequencer.sv]
// Start-up sequencer of a quad converter: APB register file, soft reset
// and initialisation, synthesizer trim/lock, foreground calibration and
// link gating by SYNC. Assumes an APB master on pclk; pins are async.
`timescale 1ns/100ps
`default_nettype none
module converter_startup_sequencer
	import startup_pkg::*;
(
	// Clock and reset.
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire startup_pkg::addr_t   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Pins from outside.
	input  wire logic                 synth_enable_strap,
	input  wire logic                 ref_input_choice_strap,
	input  wire logic                 power_down_pin,
	input  wire logic                 se_resync_pin,
	input  wire logic                 timestamp_pair,
	input  wire logic                 calibration_trigger_pin,
	input  wire logic                 rx_link_ready,
	// Pins to outside.
	output logic                      calibration_state_pin,
	output logic                      link_active,
	output logic                      data_valid,
	output logic                      aux_clocks_on,
	output logic                      serdes_ref_clock_out_en
);
	import startup_pkg::*;

	// ---------------------------------------------
	// Input synchronisers
	// ---------------------------------------------
	typedef enum {SY_HOLD, SY_TRIM, SY_LOCKING, SY_LOCKED} synth_e;
	logic [6:0]  meta_r, pins_r;
	logic        pd_s, sync_s, rx_ready_s;

	// Two flops per pin; only pins_r is read by logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 7'h00;
			pins_r <= 7'h00;
		end else begin
			meta_r <= {rx_link_ready, calibration_trigger_pin, timestamp_pair, se_resync_pin,
			           power_down_pin, ref_input_choice_strap, synth_enable_strap};
			pins_r <= meta_r;
		end
	end

	// ---------------------------------------------
	// Register file over APB
	// ---------------------------------------------
	logic [31:0] ctrl_r, ctrl_nxt, synth_r, synth_nxt, link_r, link_nxt, cala_r, cala_nxt;
	logic [31:0] calb_r, calb_nxt, sref_r, sref_nxt, ovr_r, ovr_nxt, prdata_r, prdata_nxt, status_w;
	logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt, wr_en, soft_rst, cal_busy, trim_done;
	logic        init_done_r, init_done_nxt, foreground_finished_r, foreground_finished_nxt, link_active_r, link_active_nxt;
	logic        data_valid_r, data_valid_nxt, locked;
	logic [1:0]  straps_r, straps_nxt;
	synth_e      synth_st_r, synth_st_nxt;

	assign pd_s       = pins_r[2];
	assign sync_s     = link_r[LINK_SYNC_SEL] ? pins_r[4] : pins_r[3];
	assign rx_ready_s = pins_r[6];
	assign trim_done  = (synth_st_r == SY_LOCKING) || (synth_st_r == SY_LOCKED);
	assign locked     = (synth_st_r == SY_LOCKED);
	assign wr_en      = psel && penable && pready_r && pwrite;
	// Soft reset is refused while initialising or calibrating, so the init
	// and calibration counts are never cut short.
	assign soft_rst   = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_SOFT_RESET]
	                    && init_done_r && !cal_busy;

	assign status_w = {24'h000000, straps_r, data_valid_r, link_active_r,
	                   foreground_finished_r, locked, trim_done, init_done_r};

	// No wait state: ready rises in the access phase, data set up then.
	always_comb begin
		ctrl_nxt    = ctrl_r;
		synth_nxt   = synth_r;
		link_nxt    = link_r;
		cala_nxt    = cala_r;
		calb_nxt    = calb_r;
		sref_nxt    = sref_r;
		ovr_nxt     = ovr_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			pready_nxt = 1'b1;
			case (paddr)
				ADDR_CTRL:   prdata_nxt = ctrl_r;
				ADDR_STATUS: prdata_nxt = status_w;
				ADDR_SYNTH:  prdata_nxt = synth_r;
				ADDR_LINK:   prdata_nxt = link_r;
				ADDR_CALA:   prdata_nxt = cala_r;
				ADDR_CALB:   prdata_nxt = calb_r;
				ADDR_SREF:   prdata_nxt = sref_r;
				ADDR_OVR:    prdata_nxt = ovr_r;
				default: begin
					prdata_nxt  = 32'h0000_0000;
					pslverr_nxt = 1'b1;
				end
			endcase
		end
		if (soft_rst) begin
			ctrl_nxt  = CTRL_RESET;
			synth_nxt = ZERO_RESET;
			link_nxt  = ZERO_RESET;
			cala_nxt  = ZERO_RESET;
			calb_nxt  = ZERO_RESET;
			sref_nxt  = ZERO_RESET;
			ovr_nxt   = ZERO_RESET;
		end else if (wr_en && init_done_r) begin
			// Settings only change while their engine is halted; OVR is written at any time after init.
			case (paddr)
				ADDR_CTRL: ctrl_nxt = pwdata & ~(32'h1 << CTRL_SOFT_RESET);
				ADDR_SYNTH: if (ctrl_r[CTRL_SYNTH_HOLD]) synth_nxt = pwdata;
				ADDR_LINK: if (!ctrl_r[CTRL_LINK_RUN]) link_nxt = pwdata;
				ADDR_CALA: if (!ctrl_r[CTRL_CAL_RUN]) cala_nxt = pwdata;
				ADDR_CALB: if (!ctrl_r[CTRL_CAL_RUN]) calb_nxt = pwdata;
				ADDR_SREF: if (!ctrl_r[CTRL_LINK_RUN]) sref_nxt = pwdata;
				ADDR_OVR:  ovr_nxt = pwdata;
				default:   ctrl_nxt = ctrl_r;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= CTRL_RESET;
			synth_r   <= ZERO_RESET;
			link_r    <= ZERO_RESET;
			cala_r    <= ZERO_RESET;
			calb_r    <= ZERO_RESET;
			sref_r    <= ZERO_RESET;
			ovr_r     <= ZERO_RESET;
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			synth_r   <= synth_nxt;
			link_r    <= link_nxt;
			cala_r    <= cala_nxt;
			calb_r    <= calb_nxt;
			sref_r    <= sref_nxt;
			ovr_r     <= ovr_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ---------------------------------------------
	// Engines: init, synthesizer, calibration, link
	// ---------------------------------------------
	cnt_t init_cnt_r, init_cnt_nxt, syn_cnt_r, syn_cnt_nxt, cal_cnt_r, cal_cnt_nxt;
	logic swt_prev_r, pin_prev_r, cal_pin_r, cal_pin_nxt, aux_r, aux_nxt, sref_en_r, sref_en_nxt, cal_start;

	assign cal_busy  = (cal_cnt_r != 8'h00);
	assign cal_start = ((ctrl_r[CTRL_SW_TRIG] && !swt_prev_r)
	                   || (ctrl_r[CTRL_PIN_ALLOW] && pins_r[5] && !pin_prev_r))
	                   && ctrl_r[CTRL_CAL_RUN] && init_done_r && !cala_r[CALA_BACKGROUND]
	                   && !cal_busy;

	always_comb begin
		// Initialisation count restarts on every accepted soft reset.
		init_cnt_nxt = init_cnt_r;
		if (soft_rst)
			init_cnt_nxt = INIT_CYCLES;
		else if (init_cnt_r != 8'h00)
			init_cnt_nxt = init_cnt_r - 8'h01;
		init_done_nxt = (init_cnt_nxt == 8'h00);
		// Straps follow the pins while initialising, then freeze.
		straps_nxt = init_done_r ? straps_r : pins_r[1:0];
		// Synthesizer: hold, optional auto trim, then lock.
		synth_st_nxt = synth_st_r;
		syn_cnt_nxt  = syn_cnt_r;
		if (soft_rst || !straps_r[0] || ctrl_r[CTRL_SYNTH_HOLD] || !init_done_r) begin
			synth_st_nxt = SY_HOLD;
			syn_cnt_nxt  = 8'h00;
		end else begin
			unique case (synth_st_r)
				SY_HOLD: begin
					// Manual trim needs no trim run.
					synth_st_nxt = ctrl_r[CTRL_TRIM_AUTO] ? SY_TRIM : SY_LOCKING;
					syn_cnt_nxt  = ctrl_r[CTRL_TRIM_AUTO] ? OSC_CYCLES : LOCK_CYCLES;
				end
				SY_TRIM: begin
					if (syn_cnt_r == 8'h01) begin
						synth_st_nxt = SY_LOCKING;
						syn_cnt_nxt  = LOCK_CYCLES;
					end else begin
						syn_cnt_nxt = syn_cnt_r - 8'h01;
					end
				end
				SY_LOCKING: begin
					if (syn_cnt_r == 8'h01)
						synth_st_nxt = SY_LOCKED;
					syn_cnt_nxt = syn_cnt_r - 8'h01;
				end
				SY_LOCKED: syn_cnt_nxt = 8'h00;
			endcase
		end
		// Foreground calibration; done flag cleared by a new start or a soft reset.
		cal_cnt_nxt = cal_cnt_r;
		foreground_finished_nxt = foreground_finished_r && !soft_rst;
		if (cal_start) begin
			cal_cnt_nxt = CAL_CYCLES;
			foreground_finished_nxt = 1'b0;
		end else if (cal_busy) begin
			cal_cnt_nxt = cal_cnt_r - 8'h01;
			if (cal_cnt_r == 8'h01)
				foreground_finished_nxt = 1'b1;
		end
		cal_pin_nxt = calb_r[CALB_STAT_SEL] ? locked : foreground_finished_nxt;
		// 8b/10b waits for SYNC; 64b/66b runs regardless.
		link_active_nxt = ctrl_r[CTRL_LINK_RUN] && init_done_r && !pd_s
		                  && (!is_8b10b(link_r[LINK_FMT_LSB +: 5]) || sync_s);
		data_valid_nxt  = rx_ready_s && link_active_r
		                  && ((cal_pin_r && !calb_r[CALB_STAT_SEL]) || foreground_finished_r);
		aux_nxt     = !pd_s;
		sref_en_nxt = sref_r[SREF_ENABLE] && !pd_s;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_r    <= INIT_CYCLES;
			init_done_r   <= 1'b0;
			straps_r      <= 2'b00;
			synth_st_r    <= SY_HOLD;
			syn_cnt_r     <= 8'h00;
			cal_cnt_r     <= 8'h00;
			foreground_finished_r     <= 1'b0;
			swt_prev_r    <= 1'b0;
			pin_prev_r    <= 1'b0;
			cal_pin_r     <= 1'b0;
			link_active_r <= 1'b0;
			data_valid_r  <= 1'b0;
			aux_r         <= 1'b0;
			sref_en_r     <= 1'b0;
		end else begin
			init_cnt_r    <= init_cnt_nxt;
			init_done_r   <= init_done_nxt;
			straps_r      <= straps_nxt;
			synth_st_r    <= synth_st_nxt;
			syn_cnt_r     <= syn_cnt_nxt;
			cal_cnt_r     <= cal_cnt_nxt;
			foreground_finished_r     <= foreground_finished_nxt;
			swt_prev_r    <= ctrl_r[CTRL_SW_TRIG];
			pin_prev_r    <= pins_r[5];
			cal_pin_r     <= cal_pin_nxt;
			link_active_r <= link_active_nxt;
			data_valid_r  <= data_valid_nxt;
			aux_r         <= aux_nxt;
			sref_en_r     <= sref_en_nxt;
		end
	end

	// Outputs straight from flops.
	assign prdata                  = prdata_r;
	assign pready                  = pready_r;
	assign pslverr                 = pslverr_r;
	assign calibration_state_pin   = cal_pin_r;
	assign link_active             = link_active_r;
	assign data_valid              = data_valid_r;
	assign aux_clocks_on           = aux_r;
	assign serdes_ref_clock_out_en = sref_en_r;

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	localparam int A_INIT = INIT_CYCLES;
	localparam int A_CAL  = CAL_CYCLES;
	localparam int A_LOCK = LOCK_CYCLES + 1; // One more, to reach back past the load edge.

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	init_done_time_a: assert property (soft_rst |=> !init_done_r ##A_INIT init_done_r)
		else $error("init done not set after init time");
	lock_needs_trim_a: assert property (locked |-> trim_done && straps_r[0] && init_done_r
		&& !$past(ctrl_r[CTRL_SYNTH_HOLD]))
		else $error("lock flag without trim, strap, init or hold release");
	lock_time_a: assert property ($rose(locked) |-> $past(synth_st_r, A_LOCK) == SY_HOLD
		|| $past(synth_st_r, A_LOCK) == SY_TRIM)
		else $error("lock came too early");
	cal_done_time_a: assert property (cal_start |=> !foreground_finished_r ##A_CAL foreground_finished_r)
		else $error("calibration done not set after cal time");
	cal_pin_done_a: assert property (!calb_r[CALB_STAT_SEL] && $rose(foreground_finished_r) |-> cal_pin_r)
		else $error("status pin not high with done bit");
	link_sync_wait_a: assert property (is_8b10b(link_r[4:0]) && !sync_s |=> !link_active_r)
		else $error("8b10b link active without sync");
	link_no_sync_a: assert property (ctrl_r[CTRL_LINK_RUN] && init_done_r && !pd_s
		&& !is_8b10b(link_r[4:0]) |=> link_active_r)
		else $error("64b66b link not active");
	data_valid_cause_a: assert property (data_valid_r |-> $past(rx_ready_s)
		&& ($past(foreground_finished_r) || $past(cal_pin_r)))
		else $error("data valid without ready and calibration");

	init_seen_c: cover property ($rose(init_done_r));
	lock_seen_c: cover property ($rose(locked));
	cal_seen_c:  cover property ($rose(foreground_finished_r));
	valid_seen_c: cover property ($rose(data_valid_r));
endmodule : converter_startup_sequencer
`default_nettype wire

// [design/startup_pkg.sv]
// Shared constants for the converter start-up sequencer: register map,
// field positions, reset values and timing counts.
// Assumes a 10 MHz register clock (pclk).
package startup_pkg;
	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS    = 100;
	localparam int INIT_TIME_NS     = 10000;
	localparam int OSC_TRIM_TIME_NS = 20000;
	localparam int LOCK_TIME_NS     = 5000;
	localparam int CAL_TIME_NS      = 20000;
	typedef logic [7:0] cnt_t;
	// Least times, so each rounds up to whole cycles.
	localparam cnt_t INIT_CYCLES = cnt_t'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t OSC_CYCLES  = cnt_t'((OSC_TRIM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t LOCK_CYCLES = cnt_t'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t CAL_CYCLES  = cnt_t'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// ---------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------
	typedef logic [7:0] addr_t;
	localparam addr_t ADDR_CTRL   = 8'h00;
	localparam addr_t ADDR_STATUS = 8'h04;
	localparam addr_t ADDR_SYNTH  = 8'h08;
	localparam addr_t ADDR_LINK   = 8'h0c;
	localparam addr_t ADDR_CALA   = 8'h10;
	localparam addr_t ADDR_CALB   = 8'h14;
	localparam addr_t ADDR_SREF   = 8'h18;
	localparam addr_t ADDR_OVR    = 8'h1c;
	// ---------------------------------------------
	// Control register bits
	// ---------------------------------------------
	localparam int CTRL_SOFT_RESET = 0;
	localparam int CTRL_LINK_RUN   = 1;
	localparam int CTRL_CAL_RUN    = 2;
	localparam int CTRL_SW_TRIG    = 3;
	localparam int CTRL_PIN_ALLOW  = 4;
	localparam int CTRL_SYNTH_HOLD = 5;
	localparam int CTRL_TRIM_AUTO  = 6;
	localparam int CTRL_OVR_ON     = 7;
	localparam int CTRL_LOW_POWER  = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0026;
	localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
	// ---------------------------------------------
	// Other fields
	// ---------------------------------------------
	localparam int LINK_FMT_LSB  = 0;
	localparam int LINK_KM1_LSB  = 8;
	localparam int LINK_SYNC_SEL = 16;
	localparam logic [4:0] FMT_66B_FIRST = 5'h10;
	localparam int CALA_BACKGROUND = 0;
	localparam int CALB_STAT_SEL   = 0;
	localparam int SREF_ENABLE     = 0;
	// Formats below the first 64b/66b code use 8b/10b and obey SYNC.
	function automatic logic is_8b10b(input logic [4:0] fmt);
		return fmt < FMT_66B_FIRST;
	endfunction : is_8b10b
endpackage : startup_pkg

// [dv/host_pins.sv]
// Model of the host and board pins around the start-up sequencer.
// Assumes the bench requests pin levels on pclk and runs with a stable clock.
`timescale 1ns/100ps
`default_nettype none
module host_pins #(
	parameter logic SYNTH_ON = 1'b1
) (
	// Clock, reset and bench requests.
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pd_req,
	input  wire logic [1:0] sync_req,
	input  wire logic       trig_req,
	input  wire logic       rx_req,
	// Pins toward the device.
	output logic            synth_enable_strap,
	output logic            ref_input_choice_strap,
	output logic            power_down_pin,
	output logic            se_resync_pin,
	output logic            timestamp_pair,
	output logic            calibration_trigger_pin,
	output logic            rx_link_ready
);
	// Straps are fixed from time zero; single-ended ref only with synth on.
	assign synth_enable_strap     = SYNTH_ON;
	assign ref_input_choice_strap = SYNTH_ON;
	// Pins follow requests one edge later, so they never move on the edge itself.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_pin          <= 1'b0;
			se_resync_pin           <= 1'b0;
			timestamp_pair          <= 1'b0;
			calibration_trigger_pin <= 1'b0;
			rx_link_ready           <= 1'b0;
		end else begin
			power_down_pin          <= pd_req;
			se_resync_pin           <= sync_req[0];
			timestamp_pair          <= sync_req[1];
			calibration_trigger_pin <= trig_req;
			rx_link_ready           <= rx_req;
		end
	end
endmodule : host_pins
`default_nettype wire

// [dv/converter_startup_sequencer_tb.sv]
// Self-checking bench for the start-up sequencer over APB.
// Assumes a 10 MHz pclk and the host pin model beside the device.
`timescale 1ns/100ps
`default_nettype none
module converter_startup_sequencer_tb;
	import startup_pkg::*;
	// ---------------------------------------------
	// Signals
	// ---------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sel;
	logic        pd_req, trig_req, rx_req;
	logic        synth_enable_strap, ref_input_choice_strap, power_down_pin;
	logic        se_resync_pin, timestamp_pair, calibration_trigger_pin, rx_link_ready;
	logic        calibration_state_pin, link_active, data_valid, aux_clocks_on, serdes_ref_clock_out_en;
	logic [1:0]  sync_req;
	logic [4:0]  fmt;
	addr_t       paddr;
	logic [31:0] pwdata, prdata, rd, rnd;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	converter_startup_sequencer converter_startup_sequencer_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .synth_enable_strap,
		.ref_input_choice_strap, .power_down_pin, .se_resync_pin, .timestamp_pair,
		.calibration_trigger_pin, .rx_link_ready, .calibration_state_pin, .link_active,
		.data_valid, .aux_clocks_on, .serdes_ref_clock_out_en);
	host_pins host_pins_i (.pclk, .presetn, .pd_req, .sync_req, .trig_req, .rx_req,
		.synth_enable_strap, .ref_input_choice_strap, .power_down_pin, .se_resync_pin,
		.timestamp_pair, .calibration_trigger_pin, .rx_link_ready);
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;
	// A hang ends the run well past the longest expected sequence.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			give_verdict();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Link runs on SYNC only for the 8b/10b formats below code 0x10.
	function automatic logic exp_link(input logic [4:0] f, input logic s);
		return (f < 5'h10) ? s : 1'b1;
	endfunction : exp_link
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input addr_t a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		// The slave answers in the first access cycle; only the global timeout ends a hang.
		chk(32'(n), 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input addr_t a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask : rdc
	// Status is polled with a bounded number of reads.
	task automatic poll(input logic [31:0] m);
		int n;
		n = 0;
		do begin
			apb(ADDR_STATUS, 1'b0, 32'h0);
			n++;
		end while ((rd & m) !== m && n < 150);
		chk(rd & m, m);
	endtask : poll
	task give_verdict();
		if (err_total == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		{psel, penable, pwrite, pd_req, trig_req, rx_req, presetn} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sync_req = 2'b00;
		rnd = 32'h5a7382fb;
		tick(10);
		presetn <= 1'b1;
		rdc(ADDR_CTRL, CTRL_RESET);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd & 32'h1, 32'h0);
		rnd = lfsr(rnd);
		apb(ADDR_OVR, 1'b1, rnd);
		rdc(ADDR_OVR, ZERO_RESET);
		rdc(8'h20, 32'h0);
		chk(32'(er), 32'h1);
		poll(32'h1);
		apb(ADDR_CTRL, 1'b1, CTRL_RESET | 32'h1);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd & 32'h1, 32'h0);
		poll(32'h1);
		rnd = lfsr(rnd);
		apb(ADDR_SYNTH, 1'b1, {8'h00, rnd[23:8], 8'h4a});
		rdc(ADDR_SYNTH, {8'h00, rnd[23:8], 8'h4a});
		apb(ADDR_CTRL, 1'b1, 32'h46);
		poll(32'h6);
		apb(ADDR_LINK, 1'b1, 32'h3);
		rdc(ADDR_LINK, 32'h0);
		apb(ADDR_CTRL, 1'b1, 32'h40);
		apb(ADDR_LINK, 1'b1, {16'h0, rnd[7:0], 8'h03});
		rdc(ADDR_LINK, {16'h0, rnd[7:0], 8'h03});
		apb(ADDR_CALA, 1'b1, 32'h0);
		apb(ADDR_CALB, 1'b1, 32'h0);
		apb(ADDR_SREF, 1'b1, 32'h1);
		rdc(ADDR_SREF, 32'h1);
		apb(ADDR_CTRL, 1'b1, 32'h44);
		apb(ADDR_OVR, 1'b1, rnd);
		rdc(ADDR_OVR, rnd);
		apb(ADDR_CTRL, 1'b1, 32'h46);
		tick(6);
		chk(32'(link_active), 32'h0);
		sync_req <= 2'b01;
		tick(6);
		chk({link_active, serdes_ref_clock_out_en}, 32'h3);
		apb(ADDR_CTRL, 1'b1, 32'h4e);
		tick(3);
		chk(32'(calibration_state_pin), 32'h0);
		poll(32'h8);
		chk(32'(calibration_state_pin), 32'h1);
		chk(32'(data_valid), 32'h0);
		rx_req <= 1'b1;
		tick(6);
		chk(32'(data_valid), 32'h1);
		apb(ADDR_CTRL, 1'b1, 32'h5e);
		trig_req <= 1'b1;
		tick(8);
		chk(32'(calibration_state_pin), 32'h0);
		poll(32'h8);
		// Random 8b/10b formats and SYNC sources, alternating with the 64b/66b code 0x10.
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			fmt = i[0] ? 5'h10 : {1'b0, rnd[3:0]};
			sel = rnd[8];
			apb(ADDR_CTRL, 1'b1, 32'h5c);
			apb(ADDR_LINK, 1'b1, {15'h0, sel, 11'h0, fmt});
			apb(ADDR_CTRL, 1'b1, 32'h5e);
			sync_req <= rnd[10:9];
			tick(6);
			chk(32'(link_active), 32'(exp_link(fmt, sel ? rnd[10] : rnd[9])));
		end
		// Rare modes: pin shows lock, manual trim skips the trim run, background blocks triggers.
		apb(ADDR_CTRL, 1'b1, 32'h7a);
		apb(ADDR_CALB, 1'b1, 32'h1);
		apb(ADDR_CALA, 1'b1, 32'h1);
		tick(3);
		chk(32'(calibration_state_pin), 32'h0);
		apb(ADDR_CTRL, 1'b1, 32'h1e);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd & 32'h6, 32'h2);
		poll(32'h6);
		chk(32'(calibration_state_pin), 32'h1);
		apb(ADDR_CTRL, 1'b1, 32'h16);
		apb(ADDR_CTRL, 1'b1, 32'h1e);
		apb(ADDR_STATUS, 1'b0, 32'h0);
		chk(rd & 32'h8, 32'h8);
		pd_req <= 1'b1;
		tick(6);
		chk({aux_clocks_on, link_active, serdes_ref_clock_out_en}, 32'h0);
		pd_req <= 1'b0;
		tick(6);
		chk(32'(aux_clocks_on), 32'h1);
		give_verdict();
	end
endmodule : converter_startup_sequencer_tb
`default_nettype wire
